// ==== bench/async_sram_x16_timing_test.sv ====
// Self-checking bench for the static memory controller.
// Assumes the controller, its package and the memory model are compiled first.
`default_nettype none
module async_sram_x16_timing_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        ce_in = 1'b1;
  logic        valid = 1'b0;
  logic        wr = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [1:0]  lanes = 2'h0;
  logic [7:0]  dly = 8'h0F;
  logic        ready, rdv, cs_n, we_n, oe_n, ub_n, lb_n, doe;
  logic [15:0] rdata, maddr, dbo, bus, mdata;
  logic [15:0] last = 16'h0000;
  logic [1:0]  mdrv;
  int          num_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          wcnt = 0;
  // ----------------------------------------
  // Clock, parts and bus resolution
  // ----------------------------------------
  always #5 clk_in = ~clk_in;
  sram_ctl u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_valid_in(valid), .req_write_in(wr),
    .req_addr_in(addr), .req_wdata_in(wdata), .req_lanes_in(lanes), .req_ready_out(ready), .rd_valid_out(rdv),
    .rd_data_out(rdata), .addr_out(maddr), .chip_sel_n_out(cs_n), .write_strobe_n_out(we_n),
    .out_enable_n_out(oe_n), .upper_lane_sel_n_out(ub_n), .lower_lane_sel_n_out(lb_n), .data_bus_in(bus),
    .data_bus_out(dbo), .data_bus_oe_out(doe));
  sram_model u_mem (.addr_in(maddr), .cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n), .ub_n_in(ub_n),
    .lb_n_in(lb_n), .wdata_in(dbo), .dly_in(dly), .rdata_out(mdata), .drive_out(mdrv));
  // Undriven lanes show a pattern that flips every cycle
  assign bus[15:8] = doe ? dbo[15:8] : mdrv[1] ? mdata[15:8] : ~last[15:8];
  assign bus[7:0] = doe ? dbo[7:0] : mdrv[0] ? mdata[7:0] : ~last[7:0];
  // Pin watch and hang limit
  always @(posedge clk_in) begin
    last <= rst_in ? 16'h0000 : bus;
    cyc <= cyc + 1;
    if (!rst_in) begin
      if (mdrv != 2'b00) chk({15'h0000, doe}, 16'h0000);
      if (!oe_n) chk({15'h0000, we_n}, 16'h0001);
      if (!we_n && !cs_n) chk({15'h0000, doe}, 16'h0001);
      if (!we_n) begin
        wcnt <= wcnt + 1;
      end else if (wcnt != 0) begin
        chk({15'h0000, wcnt >= 2}, 16'h0001);
        wcnt <= 0;
      end
    end
    if (cyc == 3000) begin
      num_errors++;
      results();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Hold the request until the edge after ready is seen
  task automatic req(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [1:0] l);
    @(posedge clk_in);
    valid <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    lanes <= l;
    #1;
    while (ready !== 1'b1) begin
      @(posedge clk_in);
      #1;
    end
    @(posedge clk_in);
    valid <= 1'b0;
  endtask
  // Read, check the answer delay and the selected lanes
  task automatic rd(input logic [15:0] a, input logic [1:0] l, input logic [15:0] exp);
    int n;
    logic [15:0] m;
    m = {{8{l[1]}}, {8{l[0]}}};
    n = 0;
    req(1'b0, a, 16'h0000, l);
    while (rdv !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    // Access of 15 ns rounds up to 2 cycles, plus 2 sync flops
    chk(n[15:0], 16'h0004);
    chk(rdata & m, exp & m);
  endtask
  task automatic results;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({11'h000, cs_n, we_n, oe_n, ub_n, lb_n}, 16'h001F);
    chk({14'h0000, doe, ready}, 16'h0001);
  endtask
  task automatic t_slow_word;
    req(1'b1, 16'h0012, 16'hA55A, 2'h3);
    rd(16'h0012, 2'h3, 16'hA55A);
  endtask
  task automatic t_lanes;
    req(1'b1, 16'h0034, 16'h1122, 2'h3);
    req(1'b1, 16'h0034, 16'hEEFF, 2'h2);
    req(1'b1, 16'h0034, 16'hFF77, 2'h1);
    rd(16'h0034, 2'h3, 16'hEE77);
    rd(16'h0034, 2'h1, 16'hEE77);
    rd(16'h0034, 2'h2, 16'hEE77);
  endtask
  task automatic t_noop;
    req(1'b1, 16'h0034, 16'h0000, 2'h0);
    rd(16'h0034, 2'h3, 16'hEE77);
  endtask
  task automatic t_prompt;
    dly = 8'h01;
    rd(16'h0012, 2'h3, 16'hA55A);
    rd(16'h0034, 2'h3, 16'hEE77);
    dly = 8'h0F;
  endtask
  task automatic t_freeze;
    @(posedge clk_in);
    ce_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk({15'h0000, ready}, 16'h0000);
    @(posedge clk_in);
    ce_in <= 1'b1;
    rd(16'h0012, 2'h3, 16'hA55A);
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    t_reset();
    t_slow_word();
    t_lanes();
    t_noop();
    t_prompt();
    t_freeze();
    results();
  end
endmodule
`default_nettype wire

// ==== bench/sram_model.sv ====
// Behavioural two-lane asynchronous static memory facing the controller.
// Assumes the bench resolves the shared data bus from both drive enables.
`default_nettype none
module sram_model (
  input  wire logic [15:0] addr_in,
  input  wire logic        cs_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        ub_n_in,
  input  wire logic        lb_n_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic [7:0]  dly_in,
  output logic      [15:0] rdata_out,
  output logic      [1:0]  drive_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Storage and pin behaviour
  // ----------------------------------------
  logic [15:0] mem [0:255];
  logic [20:0] prev = '0;
  logic [7:0]  age = '0;
  logic [15:0] old = '0;
  logic [1:0]  wr_on;
  // Write overlap per lane; the lane is stored when the overlap ends
  assign wr_on = {!cs_n_in && !we_n_in && !ub_n_in, !cs_n_in && !we_n_in && !lb_n_in};
  // Address and data taken at the edge that ends the write, immune to start-up ordering
  always @(negedge wr_on[1]) mem[addr_in[7:0]][15:8] = wdata_in[15:8];
  always @(negedge wr_on[0]) mem[addr_in[7:0]][7:0] = wdata_in[7:0];
  // Nanosecond age of the read inputs; old word kept briefly on change
  always #1 begin
    if ({addr_in, cs_n_in, oe_n_in, we_n_in, ub_n_in, lb_n_in} != prev) begin
      old = rdata_out;
      age = 8'h00;
    end else if (age != 8'hFF) begin
      age = age + 8'h01;
    end
    prev = {addr_in, cs_n_in, oe_n_in, we_n_in, ub_n_in, lb_n_in};
  end
  // Junk until the access time has run out
  assign rdata_out = (age < 8'h03) ? old :
                     (age >= dly_in) ? mem[addr_in[7:0]] : ~mem[addr_in[7:0]];
  // Lanes drive only in a read, released at once otherwise
  assign drive_out[1] = !cs_n_in && !oe_n_in && we_n_in && !ub_n_in;
  assign drive_out[0] = !cs_n_in && !oe_n_in && we_n_in && !lb_n_in;
endmodule
`default_nettype wire

// ==== core/sram_ctl.sv ====
// Clocked controller driving an asynchronous 16-bit two-lane static memory.
// Assumes a 100 MHz clock, synchronous reset, memory pins sampled through two flops.
`include "sram_ctl_map.svh"
`default_nettype none
module sram_ctl
  import sram_ctl_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              ce_in,
  input  wire logic              req_valid_in,
  input  wire logic              req_write_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  input  wire logic [1:0]        req_lanes_in,
  output logic                   req_ready_out,
  output logic                   rd_valid_out,
  output logic [DATA_W-1:0]      rd_data_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   chip_sel_n_out,
  output logic                   write_strobe_n_out,
  output logic                   out_enable_n_out,
  output logic                   upper_lane_sel_n_out,
  output logic                   lower_lane_sel_n_out,
  input  wire logic [DATA_W-1:0] data_bus_in,
  output logic [DATA_W-1:0]      data_bus_out,
  output logic                   data_bus_oe_out
);

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  // Read waits the longer of the address and select access times, plus two for the input sync
  localparam int RD_ACC_NS = `ADDR_ACCESS_TIME_NS > `SELECT_ACCESS_TIME_NS ?
                             `ADDR_ACCESS_TIME_NS : `SELECT_ACCESS_TIME_NS;
  localparam int RD_CYC    = `NS_TO_CYC(RD_ACC_NS) + 2;
  localparam int PULSE_NS  = `DATA_SETUP_MIN_NS + `STROBE_RELEASE_TIME_NS;
  localparam int WR_NS     = PULSE_NS > `WRITE_PULSE_MIN_NS ? PULSE_NS : `WRITE_PULSE_MIN_NS;
  localparam int WR_CYC0   = `NS_TO_CYC(WR_NS);
  localparam int WR_CYCC   = `NS_TO_CYC(`WRITE_CYCLE_MIN_NS) - 1;
  localparam int WR_CYC    = WR_CYC0 > WR_CYCC ? WR_CYC0 : WR_CYCC;
  localparam int GAP_CYC   = `NS_TO_CYC(`LANE_RELEASE_TIME_NS);
  localparam int CNT_W     = 4;

  // Cycle count less one as a sized counter load
  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n - 1);
  endfunction

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] bus_s1_r, bus_s1_nxt;
  logic [DATA_W-1:0] bus_s2_r, bus_s2_nxt;

  // Two-flop path for the returned data bus
  always_comb begin
    bus_s1_nxt = data_bus_in;
    bus_s2_nxt = bus_s1_r;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus_s1_r <= '0;
      bus_s2_r <= '0;
    end else if (ce_in) begin
      bus_s1_r <= bus_s1_nxt;
      bus_s2_r <= bus_s2_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  ctl_state_t        state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic              cs_n_r, cs_n_nxt;
  logic              we_n_r, we_n_nxt;
  logic              oe_n_r, oe_n_nxt;
  logic              drive_r, drive_nxt;
  logic [1:0]        lane_n_r, lane_n_nxt;

  // Accept requests only when idle
  assign req_ready_out = (state_r == ST_IDLE) && ce_in;

  // Next values for the pin sequence
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    cs_n_nxt   = cs_n_r;
    we_n_nxt   = we_n_r;
    oe_n_nxt   = oe_n_r;
    drive_nxt  = drive_r;
    lane_n_nxt = lane_n_r;
    unique case (state_r)
      ST_IDLE: begin
        if (req_valid_in && (req_lanes_in != 2'h0)) begin
          addr_nxt   = req_addr_in;
          lane_n_nxt = ~req_lanes_in;
          cs_n_nxt   = 1'b0;
          if (req_write_in) begin
            // All strobes fall together; overlap forms the write
            wdata_nxt = req_wdata_in;
            we_n_nxt  = 1'b0;
            oe_n_nxt  = 1'b1;
            drive_nxt = 1'b1;
            cnt_nxt   = cyc(WR_CYC);
            state_nxt = ST_WRITE;
          end else begin
            we_n_nxt  = 1'b1;
            oe_n_nxt  = 1'b0;
            drive_nxt = 1'b0;
            cnt_nxt   = cyc(RD_CYC);
            state_nxt = ST_READ;
          end
        end
      end
      ST_READ: begin
        if (cnt_r == '0) begin
          rdata_nxt  = bus_s2_r;
          rvalid_nxt = 1'b1;
          cs_n_nxt   = 1'b1;
          oe_n_nxt   = 1'b1;
          lane_n_nxt = 2'h3;
          cnt_nxt    = cyc(GAP_CYC);
          state_nxt  = ST_GAP;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_WRITE: begin
        if (cnt_r == '0) begin
          // Joint rise ends the write; data and address held a cycle
          cs_n_nxt   = 1'b1;
          we_n_nxt   = 1'b1;
          lane_n_nxt = 2'h3;
          cnt_nxt    = cyc(1);
          state_nxt  = ST_GAP;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_GAP: begin
        drive_nxt = 1'b0;
        if (cnt_r == '0) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r  <= ST_IDLE;
      cnt_r    <= '0;
      addr_r   <= '0;
      wdata_r  <= '0;
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
      cs_n_r   <= 1'b1;
      we_n_r   <= 1'b1;
      oe_n_r   <= 1'b1;
      drive_r  <= 1'b0;
      lane_n_r <= 2'h3;
    end else if (ce_in) begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      cs_n_r   <= cs_n_nxt;
      we_n_r   <= we_n_nxt;
      oe_n_r   <= oe_n_nxt;
      drive_r  <= drive_nxt;
      lane_n_r <= lane_n_nxt;
    end
  end

  // Pin and result outputs from flops
  assign addr_out             = addr_r;
  assign chip_sel_n_out       = cs_n_r;
  assign write_strobe_n_out   = we_n_r;
  assign out_enable_n_out     = oe_n_r;
  assign upper_lane_sel_n_out = lane_n_r[1];
  assign lower_lane_sel_n_out = lane_n_r[0];
  assign data_bus_out         = wdata_r;
  assign data_bus_oe_out      = drive_r;
  assign rd_data_out          = rdata_r;
  assign rd_valid_out         = rvalid_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_write_overlap_len: assert property (
    $fell(we_n_r) |-> (!we_n_r && !cs_n_r) [*2] ##1 we_n_r)
    else $error("write pulse too short");
  chk_read_strobe_high: assert property (
    !oe_n_r |-> we_n_r)
    else $error("strobe low during read");
  chk_no_drive_read: assert property (
    !oe_n_r |-> !drive_r)
    else $error("bus driven while memory may drive");
  chk_data_held_end: assert property (
    $rose(we_n_r) |-> drive_r && $stable(wdata_r))
    else $error("data not held at write end");
  chk_addr_stable_write: assert property (
    !we_n_r && !$past(we_n_r) |-> $stable(addr_r))
    else $error("address moved in write");
  chk_joint_rise: assert property (
    $rose(we_n_r) |-> $rose(cs_n_r))
    else $error("select and strobe rose apart");
  chk_read_sample_time: assert property (
    $fell(oe_n_r) |-> ##4 rvalid_r)
    else $error("read sampled at wrong time");
  chk_lanes_idle: assert property (
    cs_n_r |-> lane_n_r == 2'h3)
    else $error("lane select while deselected");

  cov_read: cover property ($fell(oe_n_r) ##[1:8] rvalid_r);
  cov_write: cover property ($fell(we_n_r) ##[1:8] $rose(we_n_r));
  cov_upper_only: cover property ($fell(cs_n_r) && lane_n_r == 2'h1);
  cov_back_to_back: cover property (rvalid_r ##[1:6] $fell(we_n_r));

endmodule
`default_nettype wire

// ==== core/sram_ctl_map.svh ====
// Timing constants and field positions for the static memory controller.
// Assumes a 100 MHz clock; counts derive from nanosecond figures, except the two sync cycles of a read and the one-cycle gap after a write.
`ifndef SRAM_CTL_MAP_SVH
`define SRAM_CTL_MAP_SVH

`define CLK_PERIOD_NS          10
// Read timing in ns
`define READ_CYCLE_MIN_NS      15
`define ADDR_ACCESS_TIME_NS    15
`define SELECT_ACCESS_TIME_NS  15
`define OUTPUT_ACCESS_TIME_NS  7
`define LANE_ACCESS_TIME_NS    7
`define LANE_RELEASE_TIME_NS   7
// Write timing in ns
`define WRITE_CYCLE_MIN_NS     15
`define WRITE_PULSE_MIN_NS     10
`define DATA_SETUP_MIN_NS      8
`define STROBE_RELEASE_TIME_NS 7
// Round up to whole cycles, never below one
`define NS_TO_CYC(ns)          (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS > 0 ? \
                                ((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS : 1)
// Lane field positions
`define UPPER_LANE_MSB         15
`define UPPER_LANE_LSB         8
`define LOWER_LANE_MSB         7
`define LOWER_LANE_LSB         0

`endif

// ==== core/sram_ctl_pkg.sv ====
// Types for the static memory controller.
// Assumes the map header is compiled alongside.
`default_nettype none
package sram_ctl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_GAP} ctl_state_t;
endpackage
`default_nettype wire
